// ==== include/timer16_consts.vh ====
// constants for the 16-bit timer: register indexes, field positions, resets
// assumes byte address = 4 * index on a 32-bit wishbone bus, data in bits 7..0
//
// Overview of operation
// - with the filter on, the capture level changes only after four equal samples
// - the filter delays a capture by four clock cycles against the raw path
// - edge select zero captures on falling edges, one on rising edges
// - a capture copies the counter into the capture register and sets the flag
// - modes using the capture register as top disable the capture input
// - clock select 0 stops; 1..5 divide the clock by 1, 8, 64, 256, 1024
// - clock select 6 counts falling, 7 rising edges of the count pin
// - the count pin is counted even when the port drives it as output
// - force strobes act only in non-pwm modes; software writes them zero otherwise
// - a force strobe applies an immediate match through the output mode bits
// - a forced match never sets a flag nor clears the counter
// - force strobe bits always read as zero
// - the counter is read and written atomically through the shared high-byte latch
// - a counter write blocks compare matches on the next timer tick
// - both compare registers are compared continuously with the counter
// - compare register writes pass through the shared high-byte latch
// - the capture flag clears on vector execution or on writing one
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH

`define IDX_CTRL_B 8'h81
`define IDX_CTRL_C 8'h82
`define IDX_CNT_LO 8'h84
`define IDX_CNT_HI 8'h85
`define IDX_CAP_LO 8'h86
`define IDX_CAP_HI 8'h87
`define IDX_CMPA_LO 8'h88
`define IDX_CMPA_HI 8'h89
`define IDX_CMPB_LO 8'h8A
`define IDX_CMPB_HI 8'h8B
`define IDX_STATUS 8'h90

`define CB_FILTER 7
`define CB_EDGE 6
`define CB_RSVD 5
`define CB_MODE_HI 4
`define CB_MODE_LO 3
`define CC_FORCE_A 7
`define CC_FORCE_B 6
`define ST_CAP_FLAG 0
`define CB_WR_MASK 8'hDF
`define REG_RESET 8'h00
`define WORD_RESET 16'h0000

`define FILTER_SAMPLES 4
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define PRESC_WIDTH 10

`define WM_NORMAL 4'h0
`define WM_CTC_A 4'h4
`define WM_PFC_CAP 4'h8
`define WM_PC_CAP 4'hA
`define WM_CTC_CAP 4'hC
`define WM_FAST_CAP 4'hE
`define TOP_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF

`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

`endif

// ==== core/capture_filter.v ====
// capture pin conditioner: two-stage synchroniser and optional majority-free
// four-sample filter; assumes the pin is already synchronous per house setting
`timescale 1ns/10ps
`include "timer16_consts.vh"

module capture_filter #(
  parameter SAMPLES = `FILTER_SAMPLES
) (
  input wire sys_clk,
  input wire reset,
  input wire pin,
  input wire filter_en,
  output reg level
);

  // ==========================================================
  // synchroniser
  reg sync_a;
  reg sync_b;
  reg [SAMPLES-1:0] hist;

  always @(posedge sys_clk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      hist <= {SAMPLES{1'b0}};
      level <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      hist <= {hist[SAMPLES-2:0], sync_b};
      // the filter costs four cycles of latency, the price of rejecting spikes
      if (!filter_en)
        level <= sync_b;
      else if (&hist)
        level <= 1'b1;
      else if (~|hist)
        level <= 1'b0;
    end
  end

endmodule

// ==== core/timer_prescaler.v ====
// clock select: turns the selected source into a one-cycle count enable
// assumes the external count edges arrive as one-cycle pulses
`timescale 1ns/10ps
`include "timer16_consts.vh"

module timer_prescaler #(
  parameter WIDTH = `PRESC_WIDTH
) (
  input wire sys_clk,
  input wire reset,
  input wire [2:0] clock_select_field,
  input wire ext_fall,
  input wire ext_rise,
  output reg tick
);

  // ==========================================================
  // free-running divider shared by all prescaled rates
  reg [WIDTH-1:0] div;

  always @(posedge sys_clk) begin
    if (reset)
      div <= {WIDTH{1'b0}};
    else
      div <= div + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always @* begin
    case (clock_select_field)
      `CS_STOP: tick = 1'b0;
      `CS_DIV1: tick = 1'b1;
      `CS_DIV8: tick = &div[2:0];
      `CS_DIV64: tick = &div[5:0];
      `CS_DIV256: tick = &div[7:0];
      `CS_DIV1024: tick = &div[9:0];
      `CS_EXT_FALL: tick = ext_fall;
      `CS_EXT_RISE: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

endmodule

// ==== core/timer16_regs.v ====
// 16-bit timer core: control b/c, counter, two compare units, capture unit,
// wishbone classic slave with 8-bit registers at word index * 4
// assumes mode bits 1..0 and compare output modes come from control a outside
`timescale 1ns/10ps
`include "timer16_consts.vh"

module timer16_regs (
  input wire sys_clk,
  input wire reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire capture_pin,
  input wire ext_count_pin,
  input wire [1:0] waveform_mode_low,
  input wire [1:0] compare_output_mode_a,
  input wire [1:0] compare_output_mode_b,
  input wire capture_vector_ack,
  output reg capture_flag,
  output reg compare_match_a,
  output reg compare_match_b,
  output reg wave_out_a,
  output reg wave_out_b,
  output wire [3:0] waveform_mode_field,
  output reg [15:0] counter_value
);

  // ==========================================================
  // register state
  reg [7:0] timer_control_b;
  reg [7:0] high_latch;
  reg [15:0] compare_reg_a;
  reg [15:0] compare_reg_b;
  reg [15:0] capture_reg;
  reg block_match;
  reg ext_s1;
  reg ext_s2;
  reg ext_prev;
  reg cap_prev;
  reg [15:0] top;
  reg [7:0] rdata;

  wire cap_level;
  wire tick;
  wire [2:0] clock_select_field;
  wire capture_noise_filter_en;
  wire capture_edge_sel;

  assign clock_select_field = timer_control_b[2:0];
  assign capture_noise_filter_en = timer_control_b[`CB_FILTER];
  assign capture_edge_sel = timer_control_b[`CB_EDGE];
  assign waveform_mode_field = {timer_control_b[`CB_MODE_HI:`CB_MODE_LO], waveform_mode_low};

  // ==========================================================
  // bus decode: answer one cycle after the request, every address acked
  wire req;
  wire wr;
  wire rd;
  wire [7:0] idx;
  wire [7:0] wbyte;

  // side effects land at the taking edge; the master holds its request until ack anyway
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign idx = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];

  always @(posedge sys_clk) begin
    if (reset)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // ==========================================================
  // mode decode
  wire non_pwm;
  wire cap_is_top;
  wire ctc_a;

  assign ctc_a = (waveform_mode_field == `WM_CTC_A);
  assign non_pwm = (waveform_mode_field == `WM_NORMAL) | ctc_a |
                   (waveform_mode_field == `WM_CTC_CAP);
  assign cap_is_top = (waveform_mode_field == `WM_PFC_CAP) |
                      (waveform_mode_field == `WM_PC_CAP) |
                      (waveform_mode_field == `WM_CTC_CAP) |
                      (waveform_mode_field == `WM_FAST_CAP);

  always @* begin
    case (waveform_mode_field)
      4'h1: top = `TOP_8BIT;
      4'h2: top = `TOP_9BIT;
      4'h3: top = `TOP_10BIT;
      4'h5: top = `TOP_8BIT;
      4'h6: top = `TOP_9BIT;
      4'h7: top = `TOP_10BIT;
      4'h4: top = compare_reg_a;
      4'h9: top = compare_reg_a;
      4'hB: top = compare_reg_a;
      4'hF: top = compare_reg_a;
      `WM_PFC_CAP: top = capture_reg;
      `WM_PC_CAP: top = capture_reg;
      `WM_CTC_CAP: top = capture_reg;
      `WM_FAST_CAP: top = capture_reg;
      default: top = `TOP_MAX;
    endcase
  end

  // ==========================================================
  // external count pin: sampled regardless of port direction
  always @(posedge sys_clk) begin
    if (reset) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_s1 <= ext_count_pin;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
    end
  end

  // three cycles from pin to count: two sync stages, then the counter takes the edge pulse formed from ext_s2
  timer_prescaler #(
    .WIDTH(`PRESC_WIDTH)
  ) u_prescaler (
    .sys_clk(sys_clk),
    .reset(reset),
    .clock_select_field(clock_select_field),
    .ext_fall(ext_prev & ~ext_s2),
    .ext_rise(~ext_prev & ext_s2),
    .tick(tick)
  );

  // ==========================================================
  // capture input
  capture_filter #(
    .SAMPLES(`FILTER_SAMPLES)
  ) u_capture_filter (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin(capture_pin),
    .filter_en(capture_noise_filter_en),
    .level(cap_level)
  );

  wire cap_edge;
  wire cap_event;
  wire top_hit;

  assign cap_edge = capture_edge_sel ? (cap_level & ~cap_prev) : (~cap_level & cap_prev);
  assign cap_event = cap_edge & ~cap_is_top;
  // with the capture register as top the flag marks reaching top instead
  assign top_hit = cap_is_top & tick & (counter_value == top);

  always @(posedge sys_clk) begin
    if (reset)
      cap_prev <= 1'b0;
    else
      cap_prev <= cap_level;
  end

  // ==========================================================
  // 16-bit access through the shared high-byte latch
  wire lo_wr_cnt;
  wire lo_wr_a;
  wire lo_wr_b;
  wire lo_wr_cap;
  wire [15:0] wword;

  assign wword = {high_latch, wbyte};
  // one latch for all 16-bit registers: interleaved 16-bit accesses clobber each other
  assign lo_wr_cnt = wr & (idx == `IDX_CNT_LO);
  assign lo_wr_a = wr & (idx == `IDX_CMPA_LO);
  assign lo_wr_b = wr & (idx == `IDX_CMPB_LO);
  assign lo_wr_cap = wr & (idx == `IDX_CAP_LO);

  always @(posedge sys_clk) begin
    if (reset) begin
      high_latch <= `REG_RESET;
    end else if (wr) begin
      case (idx)
        `IDX_CNT_HI: high_latch <= wbyte;
        `IDX_CAP_HI: high_latch <= wbyte;
        `IDX_CMPA_HI: high_latch <= wbyte;
        `IDX_CMPB_HI: high_latch <= wbyte;
        default: high_latch <= high_latch;
      endcase
    end else if (rd) begin
      case (idx)
        `IDX_CNT_LO: high_latch <= counter_value[15:8];
        `IDX_CAP_LO: high_latch <= capture_reg[15:8];
        `IDX_CMPA_LO: high_latch <= compare_reg_a[15:8];
        `IDX_CMPB_LO: high_latch <= compare_reg_b[15:8];
        default: high_latch <= high_latch;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      compare_reg_a <= `WORD_RESET;
      compare_reg_b <= `WORD_RESET;
      timer_control_b <= `REG_RESET;
    end else begin
      if (lo_wr_a)
        compare_reg_a <= wword;
      if (lo_wr_b)
        compare_reg_b <= wword;
      if (wr && idx == `IDX_CTRL_B)
        timer_control_b <= wbyte & `CB_WR_MASK;
    end
  end

  // ==========================================================
  // counter and capture register
  always @(posedge sys_clk) begin
    if (reset) begin
      counter_value <= `WORD_RESET;
      block_match <= 1'b0;
    // a cpu write wins over a tick in the same cycle and arms the match block
    end else if (lo_wr_cnt) begin
      counter_value <= wword;
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
      // match-a clear in ctc is driven by a real match only, never a force
      if (counter_value == top)
        counter_value <= `WORD_RESET;
      else
        counter_value <= counter_value + 16'h0001;
    end
  end

  always @(posedge sys_clk) begin
    if (reset)
      capture_reg <= `WORD_RESET;
    else if (lo_wr_cap)
      capture_reg <= wword;
    else if (cap_event)
      capture_reg <= counter_value;
  end

  // ==========================================================
  // capture flag: hardware set wins over any clear in the same cycle
  wire flag_clr;

  assign flag_clr = capture_vector_ack |
                    (wr && idx == `IDX_STATUS && wbyte[`ST_CAP_FLAG]);

  always @(posedge sys_clk) begin
    if (reset)
      capture_flag <= 1'b0;
    else if (cap_event | top_hit)
      capture_flag <= 1'b1;
    else if (flag_clr)
      capture_flag <= 1'b0;
  end

  // ==========================================================
  // compare units
  wire match_a;
  wire match_b;
  wire force_a;
  wire force_b;

  // the counter is compared every tick, skipped right after a cpu write
  assign match_a = tick & ~block_match & (counter_value == compare_reg_a);
  assign match_b = tick & ~block_match & (counter_value == compare_reg_b);
  // strobes are never stored, so control c always reads back as zero
  assign force_a = wr & (idx == `IDX_CTRL_C) & wbyte[`CC_FORCE_A] & non_pwm;
  assign force_b = wr & (idx == `IDX_CTRL_C) & wbyte[`CC_FORCE_B] & non_pwm;

  always @(posedge sys_clk) begin
    if (reset) begin
      compare_match_a <= 1'b0;
      compare_match_b <= 1'b0;
    end else begin
      // forced matches stay off these pulses, so no flag can follow
      compare_match_a <= match_a;
      compare_match_b <= match_b;
    end
  end

  // output actions only for non-pwm modes; pwm shaping lives outside
  function apply_com;
    input [1:0] com;
    input cur;
    begin
      case (com)
        `COM_TOGGLE: apply_com = ~cur;
        `COM_CLEAR: apply_com = 1'b0;
        `COM_SET: apply_com = 1'b1;
        default: apply_com = cur;
      endcase
    end
  endfunction

  always @(posedge sys_clk) begin
    if (reset) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      if (non_pwm && (match_a || force_a))
        wave_out_a <= apply_com(compare_output_mode_a, wave_out_a);
      if (non_pwm && (match_b || force_b))
        wave_out_b <= apply_com(compare_output_mode_b, wave_out_b);
    end
  end

  // ==========================================================
  // read mux; high bytes of 16-bit registers return the latch
  // the status index is local; the other flags of this timer live outside
  always @* begin
    case (idx)
      `IDX_CTRL_B: rdata = timer_control_b;
      `IDX_CTRL_C: rdata = `REG_RESET;
      `IDX_CNT_LO: rdata = counter_value[7:0];
      `IDX_CAP_LO: rdata = capture_reg[7:0];
      `IDX_CMPA_LO: rdata = compare_reg_a[7:0];
      `IDX_CMPB_LO: rdata = compare_reg_b[7:0];
      `IDX_CNT_HI: rdata = high_latch;
      `IDX_CAP_HI: rdata = high_latch;
      `IDX_CMPA_HI: rdata = high_latch;
      `IDX_CMPB_HI: rdata = high_latch;
      `IDX_STATUS: rdata = {7'h00, capture_flag};
      default: rdata = `REG_RESET;
    endcase
  end

  always @(posedge sys_clk) begin
    if (reset)
      wb_dat_o <= 32'h00000000;
    else if (rd)
      wb_dat_o <= {24'h000000, rdata};
  end

endmodule

// ==== verif/timer16_assertions.sv ====
// checker for timer16_regs: bus answer, counting, force strobes
// assumes the register index map of timer16_consts.vh
`timescale 1ns/10ps
`include "timer16_consts.vh"
module timer16_assertions (
  input wire sys_clk,
  input wire reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [1:0] compare_output_mode_a,
  input wire capture_flag,
  input wire compare_match_a,
  input wire compare_match_b,
  input wire wave_out_a,
  input wire [3:0] waveform_mode_field,
  input wire [15:0] counter_value
);
  // ==========
  // helpers
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire wr = take & wb_we_i & wb_sel_i[0];
  wire rd = take & !wb_we_i;
  wire [7:0] idx = wb_adr_i[9:2];
  reg [2:0] cs;
  reg [3:0] run;
  // the counter still steps at the edge that writes a new select, so skip one sample
  always @(posedge sys_clk) begin
    if (reset) begin
      cs <= 3'h0;
      run <= 4'h0;
    end else if (wr && idx == `IDX_CTRL_B) begin
      cs <= wb_dat_i[2:0];
      run <= 4'h0;
    end else if (run != 4'hF) begin
      run <= run + 4'h1;
    end
  end
  wire quiet = cs == 3'h0 && run > 4'h0;
  wire frc = quiet && wr && idx == `IDX_CTRL_C;
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_next_a: assert property (take |=> wb_ack_o) else $error("ack missing");
  rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
  rsvd_zero_a: assert property (rd && idx == `IDX_CTRL_B |=> !wb_dat_o[5])
    else $error("reserved bit set");
  force_read_a: assert property (rd && idx == `IDX_CTRL_C |=> wb_dat_o[7:6] == 2'h0)
    else $error("force bits read");
  stop_hold_a: assert property (quiet && !$past(wr) |-> $stable(counter_value))
    else $error("counter moved");
  count_up_a: assert property (cs == 3'h1 && run > 4'h0 && waveform_mode_field == `WM_NORMAL && !$past(wr)
    |-> counter_value == $past(counter_value) + 16'h0001) else $error("no count");
  force_tog_a: assert property (frc && wb_dat_i[`CC_FORCE_A] && waveform_mode_field == `WM_NORMAL
    && compare_output_mode_a == `COM_TOGGLE |=> wave_out_a != $past(wave_out_a)) else $error("no force");
  force_quiet_a: assert property (frc |=> (!compare_match_a && !compare_match_b) [*2])
    else $error("force matched");
  force_keep_a: assert property (frc |=> $stable(counter_value)) else $error("force moved counter");
  cover property (frc);
  cover property (compare_match_a);
  cover property (capture_flag);
endmodule

// ==== verif/pin_model.sv ====
// far side pins: capture source and count pin, driven as levels
// assumes the bench asks for levels; pins move just after a clock edge
`timescale 1ns/10ps
module pin_model (
  input wire sys_clk,
  input wire cap_req,
  input wire ext_req,
  output reg capture_pin,
  output reg ext_count_pin
);
  // ==========
  // pin drivers
  initial begin
    capture_pin = 1'b0;
    ext_count_pin = 1'b0;
  end
  // software drives the count pin as a port output
  always @(posedge sys_clk) begin
    capture_pin <= cap_req;
    ext_count_pin <= ext_req;
  end
endmodule

// ==== verif/tb.sv ====
// bench for timer16_regs: wishbone tasks and register sequences
// assumes ack one cycle after a request is taken
`timescale 1ns/10ps
`include "timer16_consts.vh"
module tb;
  // ==========
  // signals and tasks
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, vack = 1'b0, cap_req = 1'b0, ext_req = 1'b0;
  reg [9:0] adr = 10'h000;
  reg [31:0] dat = 32'h0;
  reg [1:0] wm_lo = 2'h0, com_a = 2'h1, com_b = 2'h0;
  wire [31:0] dat_o;
  wire ack, flag, m_a, m_b, w_a, w_b, cap_pin, ext_pin;
  wire [3:0] wmf;
  wire [15:0] cnt;
  integer num_errors = 0, total_checks = 0, cycles = 0, na = 0, nb = 0, i, d;
  reg [7:0] q;
  reg [15:0] v;
  initial forever #5 sys_clk = ~sys_clk;
  timer16_regs timer16_regs_inst (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .capture_pin(cap_pin), .ext_count_pin(ext_pin), .waveform_mode_low(wm_lo),
    .compare_output_mode_a(com_a), .compare_output_mode_b(com_b), .capture_vector_ack(vack),
    .capture_flag(flag), .compare_match_a(m_a), .compare_match_b(m_b), .wave_out_a(w_a),
    .wave_out_b(w_b), .waveform_mode_field(wmf), .counter_value(cnt));
  pin_model pin_model_inst (.sys_clk(sys_clk), .cap_req(cap_req), .ext_req(ext_req),
    .capture_pin(cap_pin), .ext_count_pin(ext_pin));
  task finish_test;
    begin
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (m_a === 1'b1)
      na = na + 1;
    if (m_b === 1'b1)
      nb = nb + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task bus(input w, input [7:0] ix, input [7:0] dv);
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      dat <= {24'h0, dv};
      @(posedge sys_clk);
      while (ack !== 1'b1)
        @(posedge sys_clk);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  // high byte first, the low write commits both
  task w16(input [7:0] lo, input [15:0] val);
    begin
      bus(1'b1, lo + 8'h01, val[15:8]);
      bus(1'b1, lo, val[7:0]);
    end
  endtask
  task r16(input [7:0] lo);
    begin
      bus(1'b0, lo, 8'h00);
      v[7:0] = q;
      bus(1'b0, lo + 8'h01, 8'h00);
      v[15:8] = q;
    end
  endtask
  task pulse(input lvl);
    begin
      cap_req <= lvl;
      repeat (12) @(posedge sys_clk);
    end
  endtask
  // ==========
  // sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (i = 8'h81; i < 8'h8C; i = i + 1) begin
      bus(1'b0, i, 8'h00);
      chk("reset", q, 16'h0000);
    end
    bus(1'b1, `IDX_CTRL_B, 8'hC0);
    bus(1'b0, `IDX_CTRL_B, 8'h00);
    chk("ctrlb", q, 16'h00C0);
    bus(1'b1, `IDX_CTRL_B, 8'h00);
    bus(1'b1, 8'h83, 8'h5A);
    bus(1'b0, 8'h83, 8'h00);
    chk("unmap", q, 16'h0000);
    w16(`IDX_CNT_LO, 16'h1234);
    bus(1'b1, `IDX_CNT_HI, 8'hAB);
    r16(`IDX_CNT_LO);
    chk("cnt", v, 16'h1234);
    w16(`IDX_CMPA_LO, 16'h0040);
    w16(`IDX_CMPB_LO, 16'h0080);
    r16(`IDX_CMPA_LO);
    chk("cmpa", v, 16'h0040);
    r16(`IDX_CMPB_LO);
    chk("cmpb", v, 16'h0080);
    bus(1'b1, `IDX_CTRL_C, 8'hC0);
    chk("forcea", w_a, 16'h0001);
    bus(1'b0, `IDX_CTRL_C, 8'h00);
    chk("ctrlc", q, 16'h0000);
    wm_lo <= 2'h1;
    bus(1'b1, `IDX_CTRL_C, 8'h80);
    chk("pwmforce", w_a, 16'h0001);
    wm_lo <= 2'h0;
    com_b <= 2'h3;
    w16(`IDX_CNT_LO, 16'h0040);
    bus(1'b1, `IDX_CTRL_B, 8'h01);
    repeat (6) @(posedge sys_clk);
    chk("blocked", na, 16'h0000);
    w16(`IDX_CNT_LO, 16'h0030);
    repeat (100) @(posedge sys_clk);
    bus(1'b1, `IDX_CTRL_B, 8'h00);
    chk("matcha", na, 16'h0001);
    chk("matchb", nb, 16'h0001);
    chk("waveb", w_b, 16'h0001);
    chk("wavea", w_a, 16'h0000);
    for (i = 2; i < 6; i = i + 1) begin
      d = (i == 2) ? 8 : (i == 3) ? 64 : (i == 4) ? 256 : 1024;
      v = cnt;
      bus(1'b1, `IDX_CTRL_B, i);
      repeat (4 * d) @(posedge sys_clk);
      bus(1'b1, `IDX_CTRL_B, 8'h00);
      chk("presc", (cnt - v >= 3) && (cnt - v <= 5), 16'h0001);
    end
    for (i = 6; i < 8; i = i + 1) begin
      v = cnt;
      bus(1'b1, `IDX_CTRL_B, i);
      repeat (5) begin
        ext_req <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext_req <= 1'b0;
        repeat (4) @(posedge sys_clk);
      end
      bus(1'b1, `IDX_CTRL_B, 8'h00);
      chk("extcnt", cnt - v, 16'h0005);
    end
    w16(`IDX_CNT_LO, 16'h0042);
    bus(1'b1, `IDX_CTRL_B, 8'h08);
    bus(1'b1, `IDX_CTRL_C, 8'h80);
    chk("ctcforce", w_a, 16'h0001);
    r16(`IDX_CNT_LO);
    chk("ctckeep", v, 16'h0042);
    bus(1'b1, `IDX_CTRL_B, 8'h40);
    cap_req <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("rawlate", flag, 16'h0000);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("caprise", flag, 16'h0001);
    repeat (7) @(posedge sys_clk);
    r16(`IDX_CAP_LO);
    chk("capval", v, 16'h0042);
    bus(1'b1, `IDX_STATUS, 8'h01);
    chk("capclr", flag, 16'h0000);
    pulse(1'b0);
    chk("nofall", flag, 16'h0000);
    bus(1'b1, `IDX_CTRL_B, 8'h00);
    pulse(1'b1);
    chk("norise", flag, 16'h0000);
    pulse(1'b0);
    chk("capfall", flag, 16'h0001);
    vack <= 1'b1;
    @(posedge sys_clk);
    vack <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("vecclr", flag, 16'h0000);
    bus(1'b1, `IDX_CTRL_B, 8'hC0);
    cap_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pulse(1'b0);
    chk("glitch", flag, 16'h0000);
    cap_req <= 1'b1;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("filtlate", flag, 16'h0000);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("filtcap", flag, 16'h0001);
    repeat (3) @(posedge sys_clk);
    bus(1'b1, `IDX_STATUS, 8'h01);
    pulse(1'b0);
    bus(1'b1, `IDX_CTRL_B, 8'h58);
    chk("wmode", wmf, 16'h000C);
    pulse(1'b1);
    chk("captop", flag, 16'h0000);
    bus(1'b1, `IDX_CTRL_B, 8'h00);
    finish_test;
  end
endmodule
bind timer16_regs timer16_assertions timer16_assertions_inst (.sys_clk(sys_clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .compare_output_mode_a(compare_output_mode_a),
  .capture_flag(capture_flag), .compare_match_a(compare_match_a), .compare_match_b(compare_match_b),
  .wave_out_a(wave_out_a), .waveform_mode_field(waveform_mode_field), .counter_value(counter_value));
